// File: core/gdc_defines.vh
// Register offsets, field positions, reset values and timing constants
`ifndef GDC_DEFINES_VH
`define GDC_DEFINES_VH

`define GDC_ADDR_W          4
`define GDC_OFS_MODE_CTRL   4'h6
`define GDC_OFS_AMP_TIMING  4'h7
`define GDC_OFS_DRIVE_STR   4'h8
`define GDC_OFS_OCP_CTRL    4'h9
`define GDC_OFS_PHA_SELECT  4'ha

`define GDC_RST_MODE_CTRL   8'h35
`define GDC_RST_AMP_TIMING  8'h50
`define GDC_RST_DRIVE_STR   8'hff
`define GDC_RST_OCP_CTRL    8'h00
`define GDC_RST_PHA_SELECT  8'h14

`define GDC_BIT_CLEAR       7
`define GDC_LOCK_HI         6
`define GDC_LOCK_LO         4
`define GDC_BIT_SCHEME      3
`define GDC_LOCK_CODE       3'h6
`define GDC_UNLOCK_CODE     3'h3
`define GDC_ROUTE_FLOAT     3'h7
`define GDC_ROUTE_LOW       3'h0

// Retry waits and sleep time
`define GDC_CLK_MHZ         100
`define GDC_RETRY_LONG_US   4000
`define GDC_RETRY_SHORT_US  70
`define GDC_SLEEP_US        850
`define GDC_RETRY_LONG_CYC  (`GDC_RETRY_LONG_US * `GDC_CLK_MHZ)
`define GDC_RETRY_SHORT_CYC (`GDC_RETRY_SHORT_US * `GDC_CLK_MHZ)
`define GDC_SLEEP_CYC       (`GDC_SLEEP_US * `GDC_CLK_MHZ)

`endif

// File: core/gdc_gate_route.v
// One gate driver input router with float handling
`timescale 1ns/1ps
`include "gdc_defines.vh"
module gdc_gate_route
(
  input  wire       clk_sys_i,
  input  wire       rst_n_i,
  input  wire [2:0] route_i,
  input  wire [5:0] gate_inputs_i,
  output reg        drive_o,
  output reg        drive_en_o
);
  reg next_drive;
  always @*
  begin
    // Code 0 forces low, 1..6 pick an input, 7 floats
    next_drive = 1'b0;
    if ((route_i != `GDC_ROUTE_LOW) && (route_i != `GDC_ROUTE_FLOAT))
      next_drive = gate_inputs_i[route_i - 3'h1]; // [RL17] [RL18]
  end
  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      drive_o    <= 1'b0;
      drive_en_o <= 1'b0;
    end
    else
    begin
      drive_o    <= next_drive;
      drive_en_o <= (route_i != `GDC_ROUTE_FLOAT); // [RL19]
    end
  end
endmodule // gdc_gate_route

// File: core/gdc_retry_timer.v
// Retry wait timer for one overcurrent detector
`timescale 1ns/1ps
`include "gdc_defines.vh"
module gdc_retry_timer
#(
  parameter LONG_CYC  = `GDC_RETRY_LONG_CYC,
  parameter SHORT_CYC = `GDC_RETRY_SHORT_CYC
)
(
  input  wire clk_sys_i,
  input  wire rst_n_i,
  input  wire start_i,
  input  wire short_i,
  output reg  busy_o
);
  reg [31:0] count;
  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      count  <= 32'h0;
      busy_o <= 1'b0;
    end
    else if (start_i && !busy_o)
    begin
      // Wait length latched at the start of the retry
      count  <= short_i ? SHORT_CYC[31:0] - 32'h1
                        : LONG_CYC[31:0] - 32'h1; // [RL14] [RL15]
      busy_o <= 1'b1;
    end
    else if (busy_o)
    begin
      if (count == 32'h0)
        busy_o <= 1'b0;
      else
        count <= count - 32'h1;
    end
  end
endmodule // gdc_retry_timer

// File: core/gdc_control_regs.v
// Gate driver control register bank
// Contract
// RL1: Writing fault-clear as one clears all set fault status flags.
// RL2: Fault-clear bit returns to zero by itself.
// RL3: Lock code in guard field blocks all writes except the guard field.
// RL4: Unlock code in guard field reenables writes to all registers.
// RL5: Other guard codes leave lock state unchanged.
// RL6: Scheme bit: zero independent high/low inputs, one PWM scheme.
// RL7: Three-bit shunt trip level selects one of eight thresholds.
// RL8: Two-bit dead time: 50, 100, 200 or 400 ns.
// RL9: Two-bit gate slew limit: 500, 1000, 2000 or 4000 ns.
// RL10: Four enable bits power back-EMF and three shunt amplifiers.
// RL11: Four-bit high-side drive strength; sink is twice source.
// RL12: Four-bit low-side drive strength, same table, sink doubled.
// RL13: Four-bit drain-source trip level in sixteen steps.
// RL14: Shunt retry wait bit: long when zero, short when one.
// RL15: Drain-source retry wait bit: long when zero, short when one.
// RL16: Two-bit filter time shared by both overcurrent detectors.
// RL17: Phase-A high route: 0 low, 1-6 inputs, 7 float.
// RL18: Phase-A low route uses the same encoding.
// RL19: Route all ones switches driver source and sink off.
// RL20: Supply-low level bit: lower when zero, higher when one.
// RL21: Comparator 1 hysteresis: band when zero, none when one.
// RL22: Latched shutdown released by fault-clear or long enable low pulse.
// RL23: Locked write to guard register updates only the guard field.
// RL24: Fault-clear is a one-cycle pulse and reads back zero.
`timescale 1ns/1ps
`include "gdc_defines.vh"
module gdc_control_regs
#(
  parameter LONG_CYC  = `GDC_RETRY_LONG_CYC,
  parameter SHORT_CYC = `GDC_RETRY_SHORT_CYC,
  parameter SLEEP_CYC = `GDC_SLEEP_CYC
)
(
  input  wire       clk_sys_i,
  input  wire       rst_n_i,
  input  wire       wr_en_i,
  input  wire       rd_en_i,
  input  wire [3:0] addr_i,
  input  wire [7:0] wr_data_i,
  output reg  [7:0] rd_data_o,
  output reg        rd_valid_o,
  input  wire       enable_pin_i,
  input  wire       shunt_trip_i,
  input  wire       drain_source_trip_i,
  input  wire [1:0] shunt_fault_response_i,
  input  wire [1:0] drain_source_fault_response_i,
  input  wire [5:0] gate_inputs_i,
  output reg        fault_clear_request_o,
  output reg        write_locked_o,
  output reg        input_scheme_select_o,
  output reg  [2:0] shunt_trip_level_o,
  output reg  [1:0] dead_time_o,
  output reg  [1:0] gate_slew_limit_o,
  output reg        backemf_amp_on_o,
  output reg        shunt_amp1_on_o,
  output reg        shunt_amp2_on_o,
  output reg        shunt_amp3_on_o,
  output reg  [3:0] high_side_drive_strength_o,
  output reg  [3:0] low_side_drive_strength_o,
  output reg  [3:0] drain_source_trip_level_o,
  output reg        shunt_retry_wait_o,
  output reg        drain_source_retry_wait_o,
  output reg  [1:0] overcurrent_filter_time_o,
  output reg        supply_low_level_select_o,
  output reg        comparator1_hysteresis_o,
  output reg        shunt_latched_o,
  output reg        drain_source_latched_o,
  output reg        shunt_retry_busy_o,
  output reg        drain_source_retry_busy_o,
  output wire       phase_a_high_drive_o,
  output wire       phase_a_high_drive_en_o,
  output wire       phase_a_low_drive_o,
  output wire       phase_a_low_drive_en_o
);
  localparam MODE_LATCH = 2'h0;
  localparam MODE_RETRY = 2'h1;
  // Reset images feed the field output flops; RST_MODE also resets mode_ctrl
  localparam [7:0] RST_MODE = `GDC_RST_MODE_CTRL;
  localparam [7:0] RST_AMP  = `GDC_RST_AMP_TIMING;
  localparam [7:0] RST_DRV  = `GDC_RST_DRIVE_STR;
  localparam [7:0] RST_OCP  = `GDC_RST_OCP_CTRL;
  localparam [7:0] RST_PHA  = `GDC_RST_PHA_SELECT;

  reg  [6:0]  mode_ctrl;
  reg  [7:0]  amp_timing;
  reg  [7:0]  drive_str;
  reg  [7:0]  ocp_ctrl;
  reg  [7:0]  pha_select;
  reg  [31:0] sleep_count;
  reg         enable_q;
  reg         next_locked;
  wire [2:0]  guard_code;
  wire        do_write;
  wire        sleep_release;
  wire        shunt_busy;
  wire        ds_busy;

  assign guard_code = wr_data_i[`GDC_LOCK_HI:`GDC_LOCK_LO];
  // Locked bank still accepts the guard field of the guard register
  assign do_write = wr_en_i && !write_locked_o; // [RL3]

  always @*
  begin
    next_locked = write_locked_o;
    if (wr_en_i && addr_i == `GDC_OFS_MODE_CTRL)
    begin
      if (guard_code == `GDC_LOCK_CODE)
        next_locked = 1'b1; // [RL3]
      else if (guard_code == `GDC_UNLOCK_CODE)
        next_locked = 1'b0; // [RL4]
      // Any other code keeps the lock as is [RL5]
    end
  end

  // Register writes; guard field always stored as written
  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      mode_ctrl  <= RST_MODE[6:0];
      amp_timing <= `GDC_RST_AMP_TIMING;
      drive_str  <= `GDC_RST_DRIVE_STR;
      ocp_ctrl   <= `GDC_RST_OCP_CTRL;
      pha_select <= `GDC_RST_PHA_SELECT;
    end
    else if (wr_en_i)
    begin
      case (addr_i)
        `GDC_OFS_MODE_CTRL:
        begin
          mode_ctrl[6:4] <= guard_code; // [RL23]
          if (do_write)
            mode_ctrl[3:0] <= wr_data_i[3:0];
        end
        `GDC_OFS_AMP_TIMING:
          if (do_write)
            amp_timing <= wr_data_i;
        `GDC_OFS_DRIVE_STR:
          if (do_write)
            drive_str <= wr_data_i;
        `GDC_OFS_OCP_CTRL:
          if (do_write)
            ocp_ctrl <= wr_data_i;
        `GDC_OFS_PHA_SELECT:
          if (do_write)
            pha_select <= wr_data_i;
        default:
          ;
      endcase
    end
  end

  // Readback; clear bit always reads zero
  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end
    else
    begin
      rd_valid_o <= rd_en_i;
      case (addr_i)
        `GDC_OFS_MODE_CTRL:  rd_data_o <= {1'b0, mode_ctrl}; // [RL24] [RL2]
        `GDC_OFS_AMP_TIMING: rd_data_o <= amp_timing;
        `GDC_OFS_DRIVE_STR:  rd_data_o <= drive_str;
        `GDC_OFS_OCP_CTRL:   rd_data_o <= ocp_ctrl;
        `GDC_OFS_PHA_SELECT: rd_data_o <= pha_select;
        default:             rd_data_o <= 8'h00;
      endcase
    end
  end

  // Long enable low pulse counts as a fault release
  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      sleep_count <= 32'h0;
      enable_q    <= 1'b1;
    end
    else
    begin
      enable_q <= enable_pin_i;
      if (enable_pin_i)
        sleep_count <= 32'h0;
      else if (sleep_count <= SLEEP_CYC[31:0])
        sleep_count <= sleep_count + 32'h1;
    end
  end
  assign sleep_release = enable_pin_i && !enable_q &&
                         (sleep_count > SLEEP_CYC[31:0]); // [RL22]

  // Field outputs and fault handling
  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      fault_clear_request_o      <= 1'b0;
      write_locked_o             <= 1'b0;
      input_scheme_select_o      <= RST_MODE[`GDC_BIT_SCHEME];
      shunt_trip_level_o         <= RST_MODE[2:0];
      dead_time_o                <= RST_AMP[7:6];
      gate_slew_limit_o          <= RST_AMP[5:4];
      backemf_amp_on_o           <= RST_AMP[3];
      shunt_amp1_on_o            <= RST_AMP[2];
      shunt_amp2_on_o            <= RST_AMP[1];
      shunt_amp3_on_o            <= RST_AMP[0];
      high_side_drive_strength_o <= RST_DRV[7:4];
      low_side_drive_strength_o  <= RST_DRV[3:0];
      drain_source_trip_level_o  <= RST_OCP[7:4];
      shunt_retry_wait_o         <= RST_OCP[3];
      drain_source_retry_wait_o  <= RST_OCP[2];
      overcurrent_filter_time_o  <= RST_OCP[1:0];
      supply_low_level_select_o  <= RST_PHA[3];
      comparator1_hysteresis_o   <= RST_PHA[7];
      shunt_latched_o            <= 1'b0;
      drain_source_latched_o     <= 1'b0;
      shunt_retry_busy_o         <= 1'b0;
      drain_source_retry_busy_o  <= 1'b0;
    end
    else
    begin
      // Pulse for one cycle on an unlocked write of one; never stored
      fault_clear_request_o <= do_write && addr_i == `GDC_OFS_MODE_CTRL &&
                               wr_data_i[`GDC_BIT_CLEAR]; // [RL1] [RL24]
      write_locked_o             <= next_locked;
      input_scheme_select_o      <= mode_ctrl[`GDC_BIT_SCHEME]; // [RL6]
      shunt_trip_level_o         <= mode_ctrl[2:0];      // [RL7]
      dead_time_o                <= amp_timing[7:6];     // [RL8]
      gate_slew_limit_o          <= amp_timing[5:4];     // [RL9]
      backemf_amp_on_o           <= amp_timing[3];       // [RL10]
      shunt_amp1_on_o            <= amp_timing[2];       // [RL10]
      shunt_amp2_on_o            <= amp_timing[1];       // [RL10]
      shunt_amp3_on_o            <= amp_timing[0];       // [RL10]
      high_side_drive_strength_o <= drive_str[7:4];      // [RL11]
      low_side_drive_strength_o  <= drive_str[3:0];      // [RL12]
      drain_source_trip_level_o  <= ocp_ctrl[7:4];       // [RL13]
      shunt_retry_wait_o         <= ocp_ctrl[3];         // [RL14]
      drain_source_retry_wait_o  <= ocp_ctrl[2];         // [RL15]
      overcurrent_filter_time_o  <= ocp_ctrl[1:0];       // [RL16]
      supply_low_level_select_o  <= pha_select[3];       // [RL20]
      comparator1_hysteresis_o   <= pha_select[7];       // [RL21]
      shunt_retry_busy_o         <= shunt_busy;
      drain_source_retry_busy_o  <= ds_busy;
      // Trip in latch mode sets latch; set wins over a same-cycle release
      if (shunt_trip_i && shunt_fault_response_i == MODE_LATCH)
        shunt_latched_o <= 1'b1;
      else if (fault_clear_request_o || sleep_release)
        shunt_latched_o <= 1'b0; // [RL22] [RL1]
      if (drain_source_trip_i &&
          drain_source_fault_response_i == MODE_LATCH)
        drain_source_latched_o <= 1'b1;
      else if (fault_clear_request_o || sleep_release)
        drain_source_latched_o <= 1'b0; // [RL22] [RL1]
    end
  end

  gdc_retry_timer #(
    .LONG_CYC  (LONG_CYC),
    .SHORT_CYC (SHORT_CYC)
  ) u_shunt_retry (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .start_i   (shunt_trip_i && shunt_fault_response_i == MODE_RETRY),
    .short_i   (ocp_ctrl[3]), // [RL14]
    .busy_o    (shunt_busy)
  );

  gdc_retry_timer #(
    .LONG_CYC  (LONG_CYC),
    .SHORT_CYC (SHORT_CYC)
  ) u_ds_retry (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .start_i   (drain_source_trip_i &&
                drain_source_fault_response_i == MODE_RETRY),
    .short_i   (ocp_ctrl[2]), // [RL15]
    .busy_o    (ds_busy)
  );

  gdc_gate_route u_high_route (
    .clk_sys_i     (clk_sys_i),
    .rst_n_i       (rst_n_i),
    .route_i       (pha_select[6:4]), // [RL17]
    .gate_inputs_i (gate_inputs_i),
    .drive_o       (phase_a_high_drive_o),
    .drive_en_o    (phase_a_high_drive_en_o)
  );

  gdc_gate_route u_low_route (
    .clk_sys_i     (clk_sys_i),
    .rst_n_i       (rst_n_i),
    .route_i       (pha_select[2:0]), // [RL18]
    .gate_inputs_i (gate_inputs_i),
    .drive_o       (phase_a_low_drive_o),
    .drive_en_o    (phase_a_low_drive_en_o)
  );
endmodule // gdc_control_regs

// File: verification/gdc_regs_sva.sv
// Port assertions for the control register bank
`timescale 1ns/1ps
module gdc_regs_sva
(
  input wire       clk_sys_i,
  input wire       rst_n_i,
  input wire       wr_en_i,
  input wire       rd_en_i,
  input wire [3:0] addr_i,
  input wire [7:0] wr_data_i,
  input wire [7:0] rd_data_o,
  input wire       rd_valid_o,
  input wire       fault_clear_request_o,
  input wire       write_locked_o,
  input wire       input_scheme_select_o,
  input wire [2:0] shunt_trip_level_o,
  input wire [1:0] dead_time_o,
  input wire [3:0] high_side_drive_strength_o,
  input wire [3:0] low_side_drive_strength_o,
  input wire       phase_a_high_drive_o,
  input wire       phase_a_high_drive_en_o,
  input wire       phase_a_low_drive_en_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire w6 = wr_en_i && addr_i == 4'h6;
  wire wa = wr_en_i && addr_i == 4'ha && !write_locked_o;
  a_clear_fires: assert property (
    w6 && wr_data_i[7] && !write_locked_o |=> fault_clear_request_o)
    else $error("clear write gave no pulse");
  a_clear_single: assert property (
    fault_clear_request_o && !(w6 && wr_data_i[7])
    |=> !fault_clear_request_o)
    else $error("clear pulse too long");
  a_clear_cause: assert property (
    $rose(fault_clear_request_o) |-> $past(w6 && wr_data_i[7]))
    else $error("clear pulse without write");
  a_lock_set: assert property (
    w6 && wr_data_i[6:4] == 3'h6 |=> write_locked_o)
    else $error("lock code did not lock");
  a_lock_clear: assert property (
    w6 && wr_data_i[6:4] == 3'h3 |=> !write_locked_o)
    else $error("unlock code did not unlock");
  a_lock_keep: assert property (
    !(w6 && (wr_data_i[6:4] == 3'h6 || wr_data_i[6:4] == 3'h3))
    |=> $stable(write_locked_o))
    else $error("lock changed without code");
  a_locked_hold: assert property (
    write_locked_o && wr_en_i && addr_i == 4'h7
    |-> ##2 dead_time_o == $past(dead_time_o, 2))
    else $error("locked write took effect");
  a_read_clear: assert property (
    rd_en_i && addr_i == 4'h6 |=> rd_valid_o && !rd_data_o[7])
    else $error("clear bit read back set");
  a_mode_fields: assert property (
    w6 && !write_locked_o |-> ##2
    {input_scheme_select_o, shunt_trip_level_o} == $past(wr_data_i[3:0], 2))
    else $error("scheme or trip level wrong");
  a_drive_fields: assert property (
    wr_en_i && addr_i == 4'h8 && !write_locked_o |-> ##2
    {high_side_drive_strength_o, low_side_drive_strength_o}
    == $past(wr_data_i, 2))
    else $error("drive strength wrong");
  a_route_float: assert property (
    wa |-> ##2
    phase_a_high_drive_en_o == ($past(wr_data_i[6:4], 2) != 3'h7) &&
    phase_a_low_drive_en_o == ($past(wr_data_i[2:0], 2) != 3'h7))
    else $error("float route wrong");
  a_route_zero: assert property (
    wa && wr_data_i[6:4] == 3'h0 |-> ##2 !phase_a_high_drive_o)
    else $error("route zero not low");
endmodule // gdc_regs_sva

// File: verification/gdc_host_model.sv
// Companion host model driving the register strobe bus
`timescale 1ns/1ps
module gdc_host_model
(
  input  wire       clk_sys_i,
  input  wire [7:0] rd_data_i,
  input  wire       rd_valid_i,
  output reg        wr_en_o,
  output reg        rd_en_o,
  output reg  [3:0] addr_o,
  output reg  [7:0] wr_data_o
);
  initial
  begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 4'h0;
    wr_data_o = 8'h00;
  end
  // Released lines show the inverse so stale values never pass
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk_sys_i);
      #1;
      addr_o = a;
      wr_data_o = d;
      wr_en_o = 1'b1;
      @(posedge clk_sys_i);
      #1;
      wr_en_o = 1'b0;
      addr_o = ~a;
      wr_data_o = ~d;
    end
  endtask
  task rd(input [3:0] a, output [7:0] d);
    integer n;
    begin
      @(posedge clk_sys_i);
      #1;
      addr_o = a;
      rd_en_o = 1'b1;
      @(posedge clk_sys_i);
      #1;
      rd_en_o = 1'b0;
      addr_o = ~a;
      @(posedge clk_sys_i);
      n = 0;
      while (rd_valid_i !== 1'b1 && n < 4)
      begin
        @(posedge clk_sys_i);
        n = n + 1;
      end
      d = rd_data_i;
      #1;
    end
  endtask
endmodule // gdc_host_model

// File: verification/tb.sv
// Self-checking bench for the control register bank
`timescale 1ns/1ps
module tb;
  reg        clk_sys_i, rst_n_i, enable_pin_i, shunt_trip_i;
  reg        drain_source_trip_i;
  reg  [1:0] shunt_fault_response_i, drain_source_fault_response_i;
  reg  [5:0] gate_inputs_i;
  reg  [7:0] d;
  wire       wr_en_i, rd_en_i, rd_valid_o, fault_clear_request_o;
  wire       write_locked_o, input_scheme_select_o, shunt_latched_o;
  wire       drain_source_latched_o, shunt_retry_busy_o;
  wire       drain_source_retry_busy_o, phase_a_high_drive_o;
  wire       phase_a_high_drive_en_o, phase_a_low_drive_o;
  wire       phase_a_low_drive_en_o;
  wire [1:0] dead_time_o;
  wire       backemf_amp_on_o, shunt_amp1_on_o, shunt_amp2_on_o;
  wire       shunt_amp3_on_o, shunt_retry_wait_o, drain_source_retry_wait_o;
  wire       supply_low_level_select_o, comparator1_hysteresis_o;
  wire [1:0] gate_slew_limit_o, overcurrent_filter_time_o;
  wire [3:0] drain_source_trip_level_o;
  wire [2:0] shunt_trip_level_o;
  wire [3:0] addr_i, high_side_drive_strength_o, low_side_drive_strength_o;
  wire [7:0] wr_data_i, rd_data_o;
  wire [7:0] busy_pair = {6'h00, shunt_retry_busy_o,
                          drain_source_retry_busy_o};
  integer    num_errors, comparisons, cyc, i, g;
  gdc_control_regs #(.LONG_CYC(40), .SHORT_CYC(7), .SLEEP_CYC(20)) DUT
  (.clk_sys_i, .rst_n_i, .wr_en_i, .rd_en_i, .addr_i, .wr_data_i,
   .rd_data_o, .rd_valid_o, .enable_pin_i, .shunt_trip_i,
   .drain_source_trip_i, .shunt_fault_response_i,
   .drain_source_fault_response_i, .gate_inputs_i,
   .fault_clear_request_o, .write_locked_o, .input_scheme_select_o,
   .shunt_trip_level_o, .dead_time_o, .gate_slew_limit_o,
   .backemf_amp_on_o, .shunt_amp1_on_o, .shunt_amp2_on_o,
   .shunt_amp3_on_o, .high_side_drive_strength_o,
   .low_side_drive_strength_o, .drain_source_trip_level_o,
   .shunt_retry_wait_o, .drain_source_retry_wait_o,
   .overcurrent_filter_time_o, .supply_low_level_select_o,
   .comparator1_hysteresis_o, .shunt_latched_o, .drain_source_latched_o,
   .shunt_retry_busy_o, .drain_source_retry_busy_o, .phase_a_high_drive_o,
   .phase_a_high_drive_en_o, .phase_a_low_drive_o, .phase_a_low_drive_en_o);
  gdc_host_model host
  (.clk_sys_i, .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o),
   .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i),
   .wr_data_o(wr_data_i));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      num_errors = num_errors + 1;
      wrap_up;
    end
  end
  task wrap_up;
    begin
      if (num_errors == 0 && comparisons > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task chkb(input got, input exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask
  task step(input integer n);
    begin
      repeat (n) @(posedge clk_sys_i);
      #1;
    end
  endtask
  function [7:0] rv(input [3:0] a);
    case (a)
      4'h6: rv = 8'h35;
      4'h7: rv = 8'h50;
      4'h8: rv = 8'hff;
      4'ha: rv = 8'h14;
      default: rv = 8'h00;
    endcase
  endfunction
  function rt(input [2:0] c);
    rt = (c == 3'h0) ? 1'b0 : gate_inputs_i[c - 3'h1];
  endfunction
  // Unmapped offsets below the bank read as zero
  task t_reset;
    for (i = 0; i < 11; i = i + 1)
    begin
      host.rd(i[3:0], d);
      chk(d, rv(i[3:0]));
    end
  endtask
  task t_fields;
    begin
      host.wr(4'h6, 8'h3b);
      host.rd(4'h6, d);
      chk(d, 8'h3b);
      chk({4'h0, input_scheme_select_o, shunt_trip_level_o},
          8'h0b);
      host.wr(4'h7, 8'ha5);
      host.rd(4'h7, d);
      chk(d, 8'ha5);
      chk({dead_time_o, gate_slew_limit_o, backemf_amp_on_o,
           shunt_amp1_on_o, shunt_amp2_on_o, shunt_amp3_on_o},
          8'ha5);
      host.wr(4'h8, 8'h3c);
      host.rd(4'h8, d);
      chk(d, 8'h3c);
      chk({high_side_drive_strength_o, low_side_drive_strength_o},
          8'h3c);
      host.wr(4'h9, 8'h5e);
      host.rd(4'h9, d);
      chk(d, 8'h5e);
      chk({drain_source_trip_level_o, shunt_retry_wait_o,
           drain_source_retry_wait_o, overcurrent_filter_time_o},
          8'h5e);
      host.wr(4'ha, 8'h88);
      host.rd(4'ha, d);
      chk(d, 8'h88);
      chk({6'h00, comparator1_hysteresis_o, supply_low_level_select_o},
          8'h03);
    end
  endtask
  task t_latch;
    begin
      shunt_trip_i = 1'b1;
      drain_source_trip_i = 1'b1;
      step(1);
      shunt_trip_i = 1'b0;
      drain_source_trip_i = 1'b0;
      step(3);
      chkb(shunt_latched_o, 1'b1);
      host.wr(4'h6, 8'hb5);
      chkb(fault_clear_request_o, 1'b1);
      step(1);
      chkb(fault_clear_request_o, 1'b0);
      step(3);
      chkb(shunt_latched_o, 1'b0);
      host.rd(4'h6, d);
      chk(d, 8'h35);
      drain_source_trip_i = 1'b1;
      step(1);
      drain_source_trip_i = 1'b0;
      enable_pin_i = 1'b0;
      step(10);
      enable_pin_i = 1'b1;
      step(3);
      chkb(drain_source_latched_o, 1'b1);
      enable_pin_i = 1'b0;
      step(25);
      chkb(drain_source_latched_o, 1'b1);
      enable_pin_i = 1'b1;
      step(3);
      chkb(drain_source_latched_o, 1'b0);
    end
  endtask
  task t_lock;
    begin
      host.wr(4'h6, 8'h6a);
      chkb(write_locked_o, 1'b1);
      host.wr(4'h7, 8'h00);
      host.rd(4'h7, d);
      chk(d, 8'ha5);
      host.wr(4'h6, 8'he5);
      chkb(fault_clear_request_o, 1'b0);
      host.rd(4'h6, d);
      chk(d, 8'h6a);
      host.wr(4'h6, 8'h5a);
      chkb(write_locked_o, 1'b1);
      host.wr(4'h6, 8'h3a);
      chkb(write_locked_o, 1'b0);
      host.wr(4'h7, 8'h00);
      host.rd(4'h7, d);
      chk(d, 8'h00);
    end
  endtask
  task t_route;
    for (g = 0; g < 2; g = g + 1)
    begin
      gate_inputs_i = g ? 6'h1a : 6'h25;
      for (i = 0; i < 8; i = i + 1)
      begin
        host.wr(4'ha, {1'b0, i[2:0], 1'b0, 3'h7 - i[2:0]});
        step(2);
        chkb(phase_a_high_drive_en_o, i != 7);
        chkb(phase_a_low_drive_en_o, i != 0);
        if (i != 7)
          chkb(phase_a_high_drive_o, rt(i[2:0]));
        if (i != 0)
          chkb(phase_a_low_drive_o, rt(3'h7 - i[2:0]));
      end
    end
  endtask
  // Busy shows for exactly the wait length, one cycle after the trip edge
  task t_retry;
    for (g = 0; g < 2; g = g + 1)
    begin
      host.wr(4'h9, g ? 8'h04 : 8'h08);
      shunt_fault_response_i = 2'h1;
      drain_source_fault_response_i = 2'h1;
      shunt_trip_i = 1'b1;
      drain_source_trip_i = 1'b1;
      step(1);
      shunt_trip_i = 1'b0;
      drain_source_trip_i = 1'b0;
      step(7);
      chk(busy_pair, 8'h03);
      step(1);
      chk(busy_pair, g ? 8'h02 : 8'h01);
      step(32);
      chk(busy_pair, g ? 8'h02 : 8'h01);
      step(1);
      chk(busy_pair, 8'h00);
    end
  endtask
  initial
  begin
    num_errors = 0;
    comparisons = 0;
    cyc = 0;
    rst_n_i = 1'b0;
    enable_pin_i = 1'b1;
    shunt_trip_i = 1'b0;
    drain_source_trip_i = 1'b0;
    shunt_fault_response_i = 2'h0;
    drain_source_fault_response_i = 2'h0;
    gate_inputs_i = 6'h00;
    step(16);
    rst_n_i = 1'b1;
    t_reset;
    t_fields;
    t_latch;
    t_lock;
    t_route;
    t_retry;
    wrap_up;
  end
endmodule // tb
bind gdc_control_regs gdc_regs_sva u_sva
  (.clk_sys_i, .rst_n_i, .wr_en_i, .rd_en_i, .addr_i, .wr_data_i,
   .rd_data_o, .rd_valid_o, .fault_clear_request_o, .write_locked_o,
   .input_scheme_select_o, .shunt_trip_level_o, .dead_time_o,
   .high_side_drive_strength_o, .low_side_drive_strength_o,
   .phase_a_high_drive_o, .phase_a_high_drive_en_o,
   .phase_a_low_drive_en_o);
